/* File: rtl/mux_adc_serial_sequencer.sv */
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// three-stage pin synchroniser; a change counts once stages 2 and 3 agree
module pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic [2:0] s_r;
  logic [2:0] s_nxt;
  logic q_r;
  logic q_nxt;

  // stage 1 feeds stage 2 only
  always_comb begin
    s_nxt = {s_r[1:0], d};
    q_nxt = (s_r[1] == s_r[2]) ? s_r[2] : q_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= 3'h0;
      q_r <= 1'h0;
    end else begin
      s_r <= s_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

module mux_adc_serial_sequencer #(
  parameter int unsigned POR_CNT = mux_adc_pkg::POR_CYCLES,
  parameter int unsigned CONV50_CNT = mux_adc_pkg::CONV_50_CYCLES,
  parameter int unsigned CONV60_CNT = mux_adc_pkg::CONV_60_CYCLES,
  parameter int unsigned RATE_TIMEOUT = mux_adc_pkg::RATE_TIMEOUT_CYCLES,
  parameter int unsigned EXT_DIV = mux_adc_pkg::EXT_WORD_DIV,
  parameter logic [16*mux_adc_pkg::NUM_CH-1:0] CHAN_MAP =
    mux_adc_pkg::CHAN_MAP_DEFAULT
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [mux_adc_pkg::ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CONVERTER_SELECT_N,
  input wire logic CHANNEL_SELECT_LATCH_N,
  input wire logic MUX_CLK,
  input wire logic MUX_DATA_IN,
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE,
  output logic RESULT_SERIAL_OUT,
  output logic RESULT_SERIAL_OE,
  input wire logic RATE_SELECT_PIN,
  input wire logic CONV_SIGN,
  input wire logic CONV_RANGE,
  input wire logic [mux_adc_pkg::CODE_BITS-1:0] CONV_CODE,
  output logic CONV_BUSY,
  output logic [mux_adc_pkg::NUM_CH-1:0] CHANNEL_ENABLE
);
  import mux_adc_pkg::*;

  logic cs_q;
  logic latch_q;
  logic mclk_q;
  logic din_q;
  logic sck_q;
  logic rate_q;

  seq_state_t state_r, state_nxt;
  logic [CNT_W-1:0] tmr_r, tmr_nxt;
  logic [CNT_W-1:0] target;
  logic [WORD_BITS-1:0] word_r, word_nxt;
  logic [WORD_BITS-1:0] result_r, result_nxt;
  logic [BITS_W-1:0] bits_r, bits_nxt;
  logic isck_r, isck_nxt;
  logic sck_r, sck_nxt;
  logic [HALF_W-1:0] half_r, half_nxt;
  logic sdo_r, sdo_nxt;
  logic [ADDR_BITS-1:0] shift_r, shift_nxt;
  logic [ADDR_BITS-1:0] chan_r, chan_nxt;
  logic [NUM_CH-1:0] chen_r, chen_nxt;
  logic rate_ext_r, rate_ext_nxt;
  logic [CNT_W-1:0] idle_r, idle_nxt;
  logic cs_prev_r, latch_prev_r, mclk_prev_r, sck_prev_r, rate_prev_r;
  logic ctrl_r, ctrl_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic cs_rise, latch_fall, mclk_rise, ext_fall, rate_rise, tick, fall;

  // pins from the host and the rate source
  pin_sync u_cs (.clk(MCLK), .rst_n(RESETN), .d(CONVERTER_SELECT_N),
    .q(cs_q));
  pin_sync u_latch (.clk(MCLK), .rst_n(RESETN), .d(CHANNEL_SELECT_LATCH_N),
    .q(latch_q));
  pin_sync u_mclk (.clk(MCLK), .rst_n(RESETN), .d(MUX_CLK), .q(mclk_q));
  pin_sync u_din (.clk(MCLK), .rst_n(RESETN), .d(MUX_DATA_IN), .q(din_q));
  pin_sync u_sck (.clk(MCLK), .rst_n(RESETN), .d(SCK_IN), .q(sck_q));
  pin_sync u_rate (.clk(MCLK), .rst_n(RESETN), .d(RATE_SELECT_PIN),
    .q(rate_q));

  // edge terms; din passes the same depth as mux clock so they stay aligned
  assign cs_rise = cs_q & ~cs_prev_r;
  assign latch_fall = latch_prev_r & ~latch_q;
  assign mclk_rise = mclk_q & ~mclk_prev_r;
  assign ext_fall = sck_prev_r & ~sck_q;
  assign rate_rise = rate_q & ~rate_prev_r;

  // channel address capture and channel enable
  always_comb begin
    shift_nxt = shift_r;
    chan_nxt = chan_r;
    if (mclk_rise && latch_q) begin
      shift_nxt = {shift_r[ADDR_BITS-2:0], din_q};
    end
    if (latch_fall) begin
      chan_nxt = shift_r;
    end
    // the map is a table because the decode differs between variants
    chen_nxt = latch_q ? '0 : CHAN_MAP[chan_nxt*NUM_CH +: NUM_CH];
  end

  // rate pin: a toggling pin means an external conversion clock
  always_comb begin
    idle_nxt = idle_r;
    rate_ext_nxt = rate_ext_r;
    if (rate_rise) begin
      idle_nxt = '0;
      rate_ext_nxt = 1'b1;
    end else if (idle_r >= CNT_W'(RATE_TIMEOUT - 1)) begin
      rate_ext_nxt = 1'b0;
    end else begin
      idle_nxt = idle_r + 1'b1;
    end
    // a static level picks the internal timing for a 50Hz or 60Hz null
    if (rate_ext_r) begin
      tick = rate_rise;
      target = CNT_W'(EXT_DIV);
    end else begin
      tick = 1'b1;
      target = rate_q ? CNT_W'(CONV50_CNT) : CNT_W'(CONV60_CNT);
    end
  end

  // sequencer: power-on, conversion, sleep, data output
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    word_nxt = word_r;
    result_nxt = result_r;
    bits_nxt = bits_r;
    isck_nxt = isck_r;
    sck_nxt = sck_r;
    half_nxt = half_r;
    fall = 1'b0;
    case (state_r)
      ST_POR: begin
        tmr_nxt = tmr_r + 1'b1;
        if (tmr_r >= CNT_W'(POR_CNT - 1)) begin
          state_nxt = ST_CONV;
          tmr_nxt = '0;
        end
      end
      ST_CONV: begin
        // calibration phases live inside this span; length is unchanged
        if (tick) begin
          tmr_nxt = tmr_r + 1'b1;
        end
        if (tick && tmr_r >= target - 1'b1) begin
          // code passes straight from the filter: FFFFF full, 00000 zero
          word_nxt = {1'b0, 1'b0, CONV_SIGN, CONV_RANGE, CONV_CODE};
          result_nxt = word_nxt;
          state_nxt = ST_SLEEP;
          tmr_nxt = '0;
        end
      end
      ST_SLEEP: begin
        // word_r is left alone here, however long the host waits
        if (!cs_q) begin
          state_nxt = ST_DOUT;
          bits_nxt = '0;
          // clock idling high at select fall asks the device for the clock
          isck_nxt = ctrl_r & sck_q;
          sck_nxt = 1'b0;
          half_nxt = '0;
        end
      end
      ST_DOUT: begin
        if (isck_r) begin
          half_nxt = half_r + 1'b1;
          if (half_r >= HALF_W'(ISCK_HALF - 1)) begin
            half_nxt = '0;
            sck_nxt = ~sck_r;
            fall = sck_r;
          end
        end else begin
          fall = ext_fall;
        end
        if (cs_rise) begin
          state_nxt = ST_CONV;
          tmr_nxt = '0;
          isck_nxt = 1'b0;
          sck_nxt = 1'b0;
        end else if (fall) begin
          word_nxt = {word_r[WORD_BITS-2:0], 1'b0};
          bits_nxt = bits_r + 1'b1;
          if (bits_r == LAST_BIT) begin
            state_nxt = ST_CONV;
            tmr_nxt = '0;
            isck_nxt = 1'b0;
          end
        end
      end
      default: begin
        state_nxt = ST_POR;
        tmr_nxt = '0;
      end
    endcase
    // status bit while busy, zero when sleeping, data bit while shifting
    if (state_nxt == ST_DOUT) begin
      sdo_nxt = word_nxt[WORD_BITS-1];
    end else begin
      sdo_nxt = (state_nxt != ST_SLEEP);
    end
  end

  // wishbone slave: one wait state, unmapped reads return zero
  always_comb begin
    ack_nxt = WB_CYC_I & WB_STB_I & ~ack_r;
    ctrl_nxt = ctrl_r;
    dat_nxt = dat_r;
    if (ack_nxt && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == REG_CTRL) begin
      ctrl_nxt = WB_DAT_I[0];
    end
    if (ack_nxt && !WB_WE_I) begin
      dat_nxt = '0;
      case (WB_ADR_I)
        REG_CTRL: dat_nxt[0] = ctrl_r;
        REG_STATUS: begin
          dat_nxt[3:0] = state_r;
          dat_nxt[ST_CHAN_LSB +: ADDR_BITS] = chan_r;
          dat_nxt[ST_LATCH_BIT] = latch_q;
          dat_nxt[ST_EXTRATE_BIT] = rate_ext_r;
          dat_nxt[ST_ISCK_BIT] = isck_r;
          dat_nxt[ST_RATE_BIT] = rate_q;
          dat_nxt[ST_BITS_LSB +: BITS_W] = bits_r;
        end
        REG_RESULT: dat_nxt[WORD_BITS-1:0] = result_r;
        default: dat_nxt = '0;
      endcase
    end
  end

  // all state; power-on leaves the channel on the disabled word
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= ST_POR;
      tmr_r <= '0;
      word_r <= '0;
      result_r <= '0;
      bits_r <= '0;
      isck_r <= 1'b0;
      sck_r <= 1'b0;
      half_r <= '0;
      sdo_r <= 1'b1;
      shift_r <= '0;
      chan_r <= CHAN_RESET_WORD;
      chen_r <= '0;
      rate_ext_r <= 1'b0;
      idle_r <= '0;
      cs_prev_r <= 1'b1;
      latch_prev_r <= 1'b0;
      mclk_prev_r <= 1'b0;
      sck_prev_r <= 1'b0;
      rate_prev_r <= 1'b0;
      ctrl_r <= CTRL_RESET;
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      word_r <= word_nxt;
      result_r <= result_nxt;
      bits_r <= bits_nxt;
      isck_r <= isck_nxt;
      sck_r <= sck_nxt;
      half_r <= half_nxt;
      sdo_r <= sdo_nxt;
      shift_r <= shift_nxt;
      chan_r <= chan_nxt;
      chen_r <= chen_nxt;
      rate_ext_r <= rate_ext_nxt;
      idle_r <= idle_nxt;
      cs_prev_r <= cs_q;
      latch_prev_r <= latch_q;
      mclk_prev_r <= mclk_q;
      sck_prev_r <= sck_q;
      rate_prev_r <= rate_q;
      ctrl_r <= ctrl_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // the pad drives only with select low; the enable is the handshake term
  assign RESULT_SERIAL_OUT = sdo_r;
  assign RESULT_SERIAL_OE = ~cs_q;
  assign SCK_OUT = sck_r;
  assign SCK_OE = (state_r == ST_DOUT) & isck_r & ~cs_q;
  assign CONV_BUSY = (state_r == ST_CONV);
  assign CHANNEL_ENABLE = chen_r;
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;
endmodule
`default_nettype wire

/* File: rtl/mux_adc_pkg.sv */
`default_nettype none
package mux_adc_pkg;
  // clock and timing figures
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned CNT_W = 25;
  localparam int unsigned POR_US = 500;
  localparam int unsigned POR_CYCLES = POR_US * CLK_MHZ;
  localparam int unsigned CONV_50_US = 160230;
  localparam int unsigned CONV_60_US = 133530;
  localparam int unsigned CONV_50_CYCLES = CONV_50_US * CLK_MHZ;
  localparam int unsigned CONV_60_CYCLES = CONV_60_US * CLK_MHZ;
  localparam int unsigned ISCK_HZ = 19200;
  localparam int unsigned ISCK_HALF = CLK_HZ / (2 * ISCK_HZ);
  localparam int unsigned HALF_W = 12;
  localparam int unsigned RATE_TIMEOUT_US = 1000;
  localparam int unsigned RATE_TIMEOUT_CYCLES = RATE_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned EXT_WORD_DIV = 20510;
  localparam int unsigned EXT_NULL_DIV = 2560;
  // output word layout
  localparam int unsigned WORD_BITS = 24;
  localparam int unsigned CODE_BITS = 20;
  localparam int unsigned BITS_W = 5;
  localparam logic [BITS_W-1:0] LAST_BIT = 5'h17;
  // channel address
  localparam int unsigned ADDR_BITS = 4;
  localparam int unsigned NUM_CH = 8;
  localparam logic [ADDR_BITS-1:0] CHAN_RESET_WORD = 4'h0;
  localparam logic [16*NUM_CH-1:0] CHAN_MAP_DEFAULT =
    128'h8040_2010_0804_0201_0000_0000_0000_0000;
  // register map
  localparam int unsigned ADR_W = 8;
  localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADR_W-1:0] REG_RESULT = 8'h08;
  localparam logic CTRL_RESET = 1'h1;
  localparam int unsigned ST_CHAN_LSB = 4;
  localparam int unsigned ST_LATCH_BIT = 8;
  localparam int unsigned ST_EXTRATE_BIT = 9;
  localparam int unsigned ST_ISCK_BIT = 10;
  localparam int unsigned ST_RATE_BIT = 11;
  localparam int unsigned ST_BITS_LSB = 16;
  // sequencer states
  typedef enum logic [3:0] {
    ST_POR   = 4'h1,
    ST_CONV  = 4'h2,
    ST_SLEEP = 4'h4,
    ST_DOUT  = 4'h8
  } seq_state_t;
endpackage
`default_nettype wire

/* File: sim/mux_adc_serial_sequencer_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// pins pass 3-stage syncs, so windows allow 6 to 8 cycles
module mux_adc_chk #(
  parameter int unsigned POR_CNT = 20
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CONVERTER_SELECT_N,
  input wire logic CHANNEL_SELECT_LATCH_N,
  input wire logic RESULT_SERIAL_OUT,
  input wire logic RESULT_SERIAL_OE,
  input wire logic CONV_BUSY,
  input wire logic [mux_adc_pkg::NUM_CH-1:0] CHANNEL_ENABLE
);
  import mux_adc_pkg::*;
  logic [15:0] up_r, up_nxt;
  logic [7:0] hi_r, hi_nxt;
  logic seen_r, seen_nxt;
  // saturating counts of cycles since reset and with select high
  always_comb begin
    up_nxt = up_r + {15'h0, ~&up_r};
    hi_nxt = CONVERTER_SELECT_N ? hi_r + {7'h0, ~&hi_r} : 8'h0;
    seen_nxt = seen_r | CONV_BUSY; // power-on phase is over
  end
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      up_r <= 16'h0;
      hi_r <= 8'h0;
      seen_r <= 1'b0;
    end else begin
      up_r <= up_nxt;
      hi_r <= hi_nxt;
      seen_r <= seen_nxt;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  a_por_launch: assert property (
    up_r == POR_CNT - 3 |-> !CONV_BUSY ##6 CONV_BUSY)
    else $error("conversion not launched on time");
  a_sleep_hold: assert property (
    seen_r && hi_r > 8'h08 && !$past(CONV_BUSY) |-> !CONV_BUSY)
    else $error("left sleep with select high");
  a_abort_conv: assert property (
    seen_r && !CONV_BUSY && RESULT_SERIAL_OE && $rose(CONVERTER_SELECT_N)
    |-> ##[1:8] CONV_BUSY)
    else $error("abort did not restart conversion");
  a_status_busy: assert property (
    CONV_BUSY && $past(CONV_BUSY) && RESULT_SERIAL_OE |-> RESULT_SERIAL_OUT)
    else $error("status low while converting");
  a_oe_off: assert property (
    CONVERTER_SELECT_N [*6] |-> !RESULT_SERIAL_OE)
    else $error("output driven with select high");
  a_oe_on: assert property (
    !CONVERTER_SELECT_N [*6] |-> RESULT_SERIAL_OE)
    else $error("output idle with select low");
  a_chan_off: assert property (
    CHANNEL_SELECT_LATCH_N [*8] |-> CHANNEL_ENABLE == '0)
    else $error("channel on while latch open");
  a_chan_hold: assert property (
    !CHANNEL_SELECT_LATCH_N [*8] |-> $stable(CHANNEL_ENABLE))
    else $error("channel moved while latch closed");
  c_sleep: cover property ($fell(CONV_BUSY));
  c_abort: cover property (seen_r && !CONV_BUSY && $rose(CONVERTER_SELECT_N));
  c_chan: cover property (CHANNEL_ENABLE != '0);
endmodule
bind mux_adc_serial_sequencer mux_adc_chk #(.POR_CNT(POR_CNT)) i_mux_adc_chk (
  .MCLK(MCLK), .RESETN(RESETN), .CONVERTER_SELECT_N(CONVERTER_SELECT_N),
  .CHANNEL_SELECT_LATCH_N(CHANNEL_SELECT_LATCH_N),
  .RESULT_SERIAL_OUT(RESULT_SERIAL_OUT), .RESULT_SERIAL_OE(RESULT_SERIAL_OE),
  .CONV_BUSY(CONV_BUSY), .CHANNEL_ENABLE(CHANNEL_ENABLE)
);
`default_nettype wire

/* File: sim/host_link.sv */
`timescale 1ns/100ps
`default_nettype none
// host end of the four-wire link; its clock stands still between frames
module host_link #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic sck_oe,
  input wire logic sck_dev,
  input wire logic result_serial_out,
  input wire logic sdo_oe,
  output logic cs_n,
  output logic latch_n,
  output logic mux_clk,
  output logic din,
  output logic sck_in
);
  logic sck_r = 1'b0;
  logic sdo_pin;
  // selects and clocks travel in pairs
  assign latch_n = cs_n;
  assign mux_clk = sck_in;
  // a floating output shows the inverse so a stale bit never passes
  assign sck_in = sck_oe ? sck_dev : sck_r;
  assign sdo_pin = sdo_oe ? result_serial_out : ~result_serial_out;
  initial begin
    cs_n = 1'b1;
    din = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  // clock level at select fall picks the clock mode
  task automatic sel(input logic cs, input logic sck);
    cs_n <= cs;
    sck_r <= sck;
  endtask
  // channel word msb first behind one stray bit, sent while asleep
  task automatic load(input logic [4:0] w);
    for (int i = 4; i >= 0; i--) begin
      din <= w[i];
      wait_n(HALF);
      sck_r <= 1'b1;
      wait_n(HALF);
      sck_r <= 1'b0;
    end
    wait_n(HALF);
  endtask
  // each bit is taken as the clock rises
  task automatic read(input int n, output logic [23:0] w);
    w = 24'h0;
    cs_n <= 1'b0;
    wait_n(HALF);
    for (int i = 0; i < n; i++) begin
      sck_r <= 1'b1;
      w = {w[22:0], sdo_pin};
      wait_n(HALF);
      sck_r <= 1'b0;
      wait_n(HALF);
    end
  endtask
endmodule
`default_nettype wire

/* File: sim/mux_adc_serial_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module mux_adc_serial_sequencer_tb;
  import mux_adc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rdo;
  logic [21:0] res = 22'h2A5A5A;
  logic [3:0] sel = 4'hF;
  logic rate = 1'b0;
  logic ack, cs_n, latch_n, mux_clk, din, sck_in, sck_out, sck_oe;
  logic result_serial_out, sdo_oe, busy;
  logic [NUM_CH-1:0] chen;
  int n_fail = 0;
  int compares = 0;
  always #5 clk = ~clk;
  // short counts keep the run brief; rate pin low picks the shorter one
  mux_adc_serial_sequencer #(
    .POR_CNT(20), .CONV50_CNT(200), .CONV60_CNT(150), .RATE_TIMEOUT(64),
    .EXT_DIV(8)
  ) i_mux_adc_serial_sequencer (
    .MCLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdo), .WB_ACK_O(ack), .CONVERTER_SELECT_N(cs_n),
    .CHANNEL_SELECT_LATCH_N(latch_n), .MUX_CLK(mux_clk), .MUX_DATA_IN(din),
    .SCK_IN(sck_in), .SCK_OUT(sck_out), .SCK_OE(sck_oe),
    .RESULT_SERIAL_OUT(result_serial_out), .RESULT_SERIAL_OE(sdo_oe),
    .RATE_SELECT_PIN(rate), .CONV_SIGN(res[21]), .CONV_RANGE(res[20]),
    .CONV_CODE(res[19:0]), .CONV_BUSY(busy), .CHANNEL_ENABLE(chen)
  );
  host_link i_host_link (
    .clk(clk), .sck_oe(sck_oe), .sck_dev(sck_out), .result_serial_out(result_serial_out),
    .sdo_oe(sdo_oe), .cs_n(cs_n), .latch_n(latch_n), .mux_clk(mux_clk),
    .din(din), .sck_in(sck_in)
  );
  task automatic test_done();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic bail();
    n_fail++;
    test_done();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic single cycle; hold until ack, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      if (ack === 1'b1) begin
        rdat = rdo;
        cyc <= 1'b0;
        @(posedge clk);
        return;
      end
    end
    bail();
  endtask
  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      if (busy === lvl) return;
    end
    bail();
  endtask
  task automatic t_regs();
    wb(1'b0, REG_CTRL, 32'h0);
    check(rdat, 32'h1);
    wb(1'b0, 8'h0C, 32'h0);
    check(rdat, 32'h0);
    // a write without byte lane 0 must leave the control bit alone
    sel <= 4'h0;
    wb(1'b1, REG_CTRL, 32'h0);
    sel <= 4'hF;
    wb(1'b0, REG_CTRL, 32'h0);
    check(rdat, 32'h1);
    // a rising rate pin flags an external clock; idling clears it later
    rate <= 1'b1;
    repeat (8) @(posedge clk);
    wb(1'b0, REG_STATUS, 32'h0);
    check(32'(rdat[11:9]), 32'h5);
    rate <= 1'b0;
    repeat (80) @(posedge clk);
    wb(1'b0, REG_STATUS, 32'h0);
    check(32'(rdat[11:9]), 32'h0);
  endtask
  task automatic t_boot();
    wait_busy(1'b1);
    check(32'(chen), 32'h0);
    wait_busy(1'b0);
    wb(1'b0, REG_STATUS, 32'h0);
    check(32'(rdat[3:0]), 32'h4);
  endtask
  // the word read belongs to the conversion just ended, new channel too
  task automatic t_frame(input logic [3:0] w, input logic [21:0] nxt);
    logic [23:0] got;
    logic [7:0] ech;
    ech = w[3] ? 8'h01 << w[2:0] : 8'h0;
    wait_busy(1'b0);
    i_host_link.load({1'b1, w});
    i_host_link.read(24, got);
    check(32'(got), {10'h0, res});
    check(32'(busy & result_serial_out), 32'h1);
    check(32'(chen), 32'(ech));
    res <= nxt;
    i_host_link.sel(1'b1, 1'b0);
  endtask
  // inputs move during sleep; the held word must not
  task automatic t_abort();
    logic [23:0] got;
    logic [21:0] held;
    wait_busy(1'b0);
    held = res;
    res <= 22'h0AAAAA;
    i_host_link.read(5, got);
    check(32'(got), {29'h0, held[21:19]});
    i_host_link.sel(1'b1, 1'b0);
    wait_busy(1'b1);
  endtask
  // clock high at select fall asks for the device clock, if enabled
  task automatic t_mode();
    wb(1'b1, REG_CTRL, 32'h0);
    wait_busy(1'b0);
    i_host_link.sel(1'b0, 1'b1);
    i_host_link.wait_n(40);
    check(32'(sck_oe), 32'h0);
    i_host_link.sel(1'b1, 1'b0);
    wait_busy(1'b1);
    wb(1'b1, REG_CTRL, 32'h1);
    wait_busy(1'b0);
    i_host_link.sel(1'b0, 1'b1);
    for (int i = 0; i < 40 && sck_oe !== 1'b1; i++)
      @(posedge clk);
    check(32'(sck_oe), 32'h1);
    i_host_link.sel(1'b1, 1'b0);
    wait_busy(1'b1);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_boot();
    t_frame(4'hA, 22'h1FFFFF);
    t_frame(4'hF, 22'h200000);
    t_frame(4'h3, 22'h35A5A5);
    t_abort();
    t_mode();
    test_done();
  end
endmodule
`default_nettype wire
